/* File: rtl/fsc_class_if.sv */
// interface: fault requests into the classifier and its decision back out
`timescale 1ns/10ps
interface fsc_class_if;
    import fsc_pkg::*;
    logic vector_read_error_flag_err;
    logic [FSC_PROT_N-1:0] prot_err;
    logic [FSC_BUS_N-1:0] bus_err;
    logic [FSC_USE_N-1:0] use_err;
    logic [8:0] prio;
    logic [2:0] enable;
    logic [3:0] exec_prio;
    logic bus_entry_push;
    logic nmi_active;
    logic hard_active;
    logic take;
    fsc_class_t cls;
    logic escalated;
    logic lockup_req;
    modport top (
        output vector_read_error_flag_err, prot_err, bus_err, use_err, prio, enable, exec_prio,
        output bus_entry_push, nmi_active, hard_active,
        input take, cls, escalated, lockup_req
    );
    modport cls_end (
        input vector_read_error_flag_err, prot_err, bus_err, use_err, prio, enable, exec_prio,
        input bus_entry_push, nmi_active, hard_active,
        output take, cls, escalated, lockup_req
    );
endinterface : fsc_class_if

/* File: rtl/fsc_classify.sv */
// module: sorts a fault into its class and decides escalation and lockup
`timescale 1ns/10ps
module fsc_classify
    import fsc_pkg::*;
(
    fsc_class_if.cls_end c
);
    logic prot_any;
    logic bus_any;
    logic use_any;
    logic [2:0] new_prio;
    logic new_en;
    logic busy_fixed;
    logic no_preempt;
    logic push_exempt;

    function automatic logic [2:0] prio_of(input logic [8:0] p, input fsc_class_t k);
        unique case (k)
            FSC_CLS_PROT: prio_of = p[FSC_PRIO_PROT +: FSC_PRIO_W];
            FSC_CLS_BUS: prio_of = p[FSC_PRIO_BUS +: FSC_PRIO_W];
            FSC_CLS_USE: prio_of = p[FSC_PRIO_USE +: FSC_PRIO_W];
            FSC_CLS_HARD: prio_of = 3'h0;
        endcase
    endfunction : prio_of

    always_comb begin
        prot_any = |c.prot_err;
        bus_any = |c.bus_err;
        use_any = |c.use_err;
        // simultaneous faults: the most severe class is taken, all flags still record
        if (c.vector_read_error_flag_err) begin
            c.cls = FSC_CLS_HARD;
        end else if (prot_any) begin
            c.cls = FSC_CLS_PROT;
        end else if (bus_any) begin
            c.cls = FSC_CLS_BUS;
        end else begin
            c.cls = FSC_CLS_USE;
        end
        new_prio = prio_of(c.prio, c.cls);
        unique case (c.cls)
            FSC_CLS_PROT: new_en = c.enable[FSC_EN_PROT];
            FSC_CLS_BUS: new_en = c.enable[FSC_EN_BUS];
            FSC_CLS_USE: new_en = c.enable[FSC_EN_USE];
            FSC_CLS_HARD: new_en = 1'b1;
        endcase
        busy_fixed = c.nmi_active | c.hard_active;
        // same or lower urgency than the running handler cannot preempt it
        no_preempt = busy_fixed | ({1'b0, new_prio} >= c.exec_prio);
        // a bus error pushing the bus fault frame runs the handler anyway
        push_exempt = (c.cls == FSC_CLS_BUS) & c.bus_err[FSC_BUS_PUSH] & c.bus_entry_push;
        c.take = c.vector_read_error_flag_err | prot_any | bus_any | use_any;
        c.escalated = c.take & (c.cls != FSC_CLS_HARD) & ~push_exempt
                      & (~new_en | no_preempt);
        // hard fault preempts all but nmi and another hard fault
        c.lockup_req = c.take & ((c.cls == FSC_CLS_HARD) | c.escalated) & busy_fixed;
    end
endmodule : fsc_classify

/* File: rtl/fsc_pkg.sv */
// package: constants, field layouts and types for the fault and sleep controller
package fsc_pkg;
    // register byte offsets on the wishbone slave
    localparam int FSC_ADR_W = 8;
    localparam logic [7:0] FSC_OFS_SEVERE = 8'h00;
    localparam logic [7:0] FSC_OFS_PROT = 8'h04;
    localparam logic [7:0] FSC_OFS_BUSERR = 8'h08;
    localparam logic [7:0] FSC_OFS_MISUSE = 8'h0C;
    localparam logic [7:0] FSC_OFS_PROT_ADDR = 8'h10;
    localparam logic [7:0] FSC_OFS_BUS_ADDR = 8'h14;
    localparam logic [7:0] FSC_OFS_SLEEP_CTRL = 8'h18;
    localparam logic [7:0] FSC_OFS_FAULT_PRIO = 8'h1C;
    localparam logic [7:0] FSC_OFS_HANDLER_EN = 8'h20;
    localparam logic [7:0] FSC_OFS_STATE = 8'h24;

    // severe_fault_cause_reg fields
    localparam int FSC_SEV_VECTOR_READ_ERROR_FLAG = 0;
    localparam int FSC_SEV_ESC = 1;
    // protection_fault_cause_reg fields: fetch, data, push, pop
    localparam int FSC_PROT_N = 4;
    localparam int FSC_PROT_FETCH = 0;
    // bus_error_cause_reg fields: push, pop, prefetch, precise, deferred
    localparam int FSC_BUS_N = 5;
    localparam int FSC_BUS_PUSH = 0;
    localparam int FSC_BUS_DEFER = 4;
    // misuse_fault_cause_reg fields: coproc, opcode, state, return, align, divisor
    localparam int FSC_USE_N = 6;
    // system_sleep_control_reg fields
    localparam int FSC_SC_DEEP = 0;
    localparam int FSC_SC_AFTER = 1;
    localparam int FSC_SC_PEND = 2;
    // fault_priority_reg: three-bit fields for protection, bus, misuse
    localparam int FSC_PRIO_W = 3;
    localparam int FSC_PRIO_PROT = 0;
    localparam int FSC_PRIO_BUS = 3;
    localparam int FSC_PRIO_USE = 6;
    // handler_enable_reg fields
    localparam int FSC_EN_PROT = 0;
    localparam int FSC_EN_BUS = 1;
    localparam int FSC_EN_USE = 2;
    // state register fields
    localparam int FSC_ST_LOCK = 0;
    localparam int FSC_ST_SLEEP = 1;
    localparam int FSC_ST_EVENT = 2;

    // executing priority: 0..7 for a configurable handler, this code for thread mode
    localparam logic [3:0] FSC_THREAD_PRIO = 4'h8;

    // reset values
    localparam logic [2:0] FSC_RST_SLEEP_CTRL = 3'h0;
    localparam logic [8:0] FSC_RST_PRIO = 9'h000;
    localparam logic [2:0] FSC_RST_EN = 3'h0;

    typedef enum logic [1:0] {
        FSC_CLS_HARD = 2'b00,
        FSC_CLS_PROT = 2'b01,
        FSC_CLS_BUS = 2'b10,
        FSC_CLS_USE = 2'b11
    } fsc_class_t;

    typedef enum logic [1:0] {
        FSC_RUN = 2'b00,
        FSC_SLEEP_INT = 2'b01,
        FSC_SLEEP_EVT = 2'b10,
        FSC_LOCKED = 2'b11
    } fsc_state_t;
endpackage : fsc_pkg

/* File: rtl/fsc_top.sv */
// module: fault status, escalation, lockup and sleep control with wishbone registers
`timescale 1ns/10ps
module fsc_top
    import fsc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [FSC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // fault sources, one-cycle pulses
    input wire logic vector_read_error_flag_err_i,
    input wire logic [FSC_PROT_N-1:0] prot_err_i,
    input wire logic no_execute_fetch_i,
    input wire logic [31:0] prot_addr_i,
    input wire logic [FSC_BUS_N-1:0] bus_err_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic [FSC_USE_N-1:0] use_err_i,
    // execution context
    input wire logic [3:0] exec_prio_i,
    input wire logic bus_entry_push_i,
    input wire logic nmi_active_i,
    input wire logic hard_active_i,
    input wire logic nmi_i,
    input wire logic debug_halt_i,
    // instructions and interrupt controller
    input wire logic wait_interrupt_instr_i,
    input wire logic wait_event_instr_i,
    input wire logic send_event_instr_i,
    input wire logic exit_to_thread_i,
    input wire logic entry_able_i,
    input wire logic new_pending_i,
    input wire logic interrupt_mask_bit_i,
    input wire logic fault_mask_bit_i,
    // fault decision
    output logic fault_take_o,
    output fsc_class_t fault_class_o,
    // core state
    output logic lockup_o,
    output logic issue_stop_o,
    output logic defer_handler_o,
    // power control
    output logic cpu_clk_gate_o,
    output logic sys_clk_stop_o,
    output logic pll_off_o,
    output logic flash_off_o
);
    fsc_class_if cif ();

    logic req;
    logic rd_take;
    logic wr_en;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rd_mux;
    logic [1:0] severe_q;
    logic [FSC_PROT_N-1:0] prot_q;
    logic [FSC_BUS_N-1:0] buserr_q;
    logic [FSC_USE_N-1:0] misuse_q;
    logic [31:0] prot_addr_q;
    logic [31:0] bus_addr_q;
    logic [2:0] sleep_ctrl_q;
    logic [8:0] prio_q;
    logic [2:0] enable_q;
    logic [FSC_PROT_N-1:0] prot_evt;
    logic [31:0] wmask;
    logic [31:0] sc_merged;
    logic [31:0] prio_merged;
    logic [31:0] en_merged;
    logic event_q;
    logic lock_nmi_q;
    logic defer_q;
    fsc_state_t state_q;
    logic sleeping;

    // byte lanes of a write turned into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // wishbone: the request is acknowledged one cycle after it appears
    assign req = wb_cyc_i & wb_stb_i;
    assign rd_take = req & ~ack_q;
    assign wr_en = req & wb_we_i & ack_q;
    assign wmask = lane_mask(wb_sel_i);
    assign sc_merged = merge({29'h0, sleep_ctrl_q}, wb_dat_i, wmask);
    assign prio_merged = merge({23'h0, prio_q}, wb_dat_i, wmask);
    assign en_merged = merge({29'h0, enable_q}, wb_dat_i, wmask);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= rd_take;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            FSC_OFS_SEVERE: rd_mux[1:0] = severe_q;
            FSC_OFS_PROT: rd_mux[FSC_PROT_N-1:0] = prot_q;
            FSC_OFS_BUSERR: rd_mux[FSC_BUS_N-1:0] = buserr_q;
            FSC_OFS_MISUSE: rd_mux[FSC_USE_N-1:0] = misuse_q;
            FSC_OFS_PROT_ADDR: rd_mux = prot_addr_q;
            FSC_OFS_BUS_ADDR: rd_mux = bus_addr_q;
            FSC_OFS_SLEEP_CTRL: rd_mux[2:0] = sleep_ctrl_q;
            FSC_OFS_FAULT_PRIO: rd_mux[8:0] = prio_q;
            FSC_OFS_HANDLER_EN: rd_mux[2:0] = enable_q;
            // the event latch is deliberately not visible here
            FSC_OFS_STATE: rd_mux[FSC_ST_SLEEP:FSC_ST_LOCK] = {sleeping, lockup_o};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdat_q <= rd_mux;
        end
    end

    // fault classification
    assign prot_evt = prot_err_i | {{(FSC_PROT_N-1){1'b0}}, no_execute_fetch_i};
    assign cif.vector_read_error_flag_err = vector_read_error_flag_err_i;
    assign cif.prot_err = prot_evt;
    assign cif.bus_err = bus_err_i;
    assign cif.use_err = use_err_i;
    assign cif.prio = prio_q;
    assign cif.enable = enable_q;
    assign cif.exec_prio = exec_prio_i;
    assign cif.bus_entry_push = bus_entry_push_i;
    assign cif.nmi_active = nmi_active_i;
    assign cif.hard_active = hard_active_i;

    fsc_classify u_classify (
        .c(cif)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_take_o <= 1'b0;
            fault_class_o <= FSC_CLS_HARD;
        end else begin
            fault_take_o <= cif.take;
            fault_class_o <= cif.escalated ? FSC_CLS_HARD : cif.cls;
        end
    end

    // sticky cause flags, write one to clear; a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            severe_q <= 2'b00;
            prot_q <= '0;
            buserr_q <= '0;
            misuse_q <= '0;
        end else begin
            severe_q[FSC_SEV_VECTOR_READ_ERROR_FLAG] <= (severe_q[FSC_SEV_VECTOR_READ_ERROR_FLAG]
                & ~(wr_en && wb_adr_i == FSC_OFS_SEVERE
                    && wb_dat_i[FSC_SEV_VECTOR_READ_ERROR_FLAG] && wmask[FSC_SEV_VECTOR_READ_ERROR_FLAG]))
                | vector_read_error_flag_err_i;
            severe_q[FSC_SEV_ESC] <= (severe_q[FSC_SEV_ESC]
                & ~(wr_en && wb_adr_i == FSC_OFS_SEVERE
                    && wb_dat_i[FSC_SEV_ESC] && wmask[FSC_SEV_ESC]))
                | cif.escalated;
            prot_q <= (prot_q & ~((wr_en && wb_adr_i == FSC_OFS_PROT) ?
                       wb_dat_i[FSC_PROT_N-1:0] & wmask[FSC_PROT_N-1:0] : '0))
                      | prot_evt;
            buserr_q <= (buserr_q & ~((wr_en && wb_adr_i == FSC_OFS_BUSERR) ?
                         wb_dat_i[FSC_BUS_N-1:0] & wmask[FSC_BUS_N-1:0] : '0))
                        | bus_err_i;
            misuse_q <= (misuse_q & ~((wr_en && wb_adr_i == FSC_OFS_MISUSE) ?
                         wb_dat_i[FSC_USE_N-1:0] & wmask[FSC_USE_N-1:0] : '0))
                        | use_err_i;
        end
    end

    // the severe flags clear only on a one in the data, like the others
    // address capture: a deferred data error carries no address, so it is not captured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_addr_q <= 32'h0000_0000;
            bus_addr_q <= 32'h0000_0000;
        end else begin
            if (|prot_evt) begin
                prot_addr_q <= prot_addr_i;
            end
            if (|bus_err_i[FSC_BUS_DEFER-1:0]) begin
                bus_addr_q <= bus_addr_i;
            end
        end
    end

    // software configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_ctrl_q <= FSC_RST_SLEEP_CTRL;
            prio_q <= FSC_RST_PRIO;
            enable_q <= FSC_RST_EN;
        end else if (wr_en) begin
            if (wb_adr_i == FSC_OFS_SLEEP_CTRL) begin
                sleep_ctrl_q <= sc_merged[2:0];
            end
            if (wb_adr_i == FSC_OFS_FAULT_PRIO) begin
                prio_q <= prio_merged[8:0];
            end
            if (wb_adr_i == FSC_OFS_HANDLER_EN) begin
                enable_q <= en_merged[2:0];
            end
        end
    end

    // event latch: send-event and wake-on-pending set it, a sleepless wait clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q <= 1'b0;
        end else if (send_event_instr_i) begin
            event_q <= 1'b1;
        end else if (sleep_ctrl_q[FSC_SC_PEND] && new_pending_i) begin
            event_q <= 1'b1;
        end else if (state_q == FSC_RUN && wait_event_instr_i) begin
            event_q <= 1'b0;
        end
    end

    // core state: run, the two sleeps and lockup
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= FSC_RUN;
            lock_nmi_q <= 1'b0;
            defer_q <= 1'b0;
        end else begin
            unique case (state_q)
                FSC_RUN: begin
                    if (cif.lockup_req) begin
                        state_q <= FSC_LOCKED;
                        lock_nmi_q <= nmi_active_i;
                    end else if (wait_interrupt_instr_i && !entry_able_i) begin
                        state_q <= FSC_SLEEP_INT;
                    end else if (wait_event_instr_i && !event_q && !send_event_instr_i) begin
                        state_q <= FSC_SLEEP_EVT;
                    end else if (exit_to_thread_i && sleep_ctrl_q[FSC_SC_AFTER]) begin
                        state_q <= FSC_SLEEP_INT;
                    end
                    if (defer_q && !interrupt_mask_bit_i) begin
                        defer_q <= 1'b0;
                    end
                end
                FSC_SLEEP_INT: begin
                    if (entry_able_i) begin
                        state_q <= FSC_RUN;
                        defer_q <= interrupt_mask_bit_i & ~fault_mask_bit_i;
                    end
                end
                FSC_SLEEP_EVT: begin
                    if (entry_able_i || (sleep_ctrl_q[FSC_SC_PEND] && new_pending_i)) begin
                        state_q <= FSC_RUN;
                    end
                end
                FSC_LOCKED: begin
                    // only a debug halt or a usable nmi ends lockup short of reset
                    if (debug_halt_i || (nmi_i && !lock_nmi_q)) begin
                        state_q <= FSC_RUN;
                        lock_nmi_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign sleeping = (state_q == FSC_SLEEP_INT) || (state_q == FSC_SLEEP_EVT);
    assign lockup_o = (state_q == FSC_LOCKED);
    assign issue_stop_o = sleeping | lockup_o;
    assign defer_handler_o = defer_q;

    // light sleep gates only the cpu clock; deep sleep takes everything down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_gate_o <= 1'b0;
            sys_clk_stop_o <= 1'b0;
            pll_off_o <= 1'b0;
            flash_off_o <= 1'b0;
        end else begin
            cpu_clk_gate_o <= sleeping;
            sys_clk_stop_o <= sleeping & sleep_ctrl_q[FSC_SC_DEEP];
            pll_off_o <= sleeping & sleep_ctrl_q[FSC_SC_DEEP];
            flash_off_o <= sleeping & sleep_ctrl_q[FSC_SC_DEEP];
        end
    end
endmodule : fsc_top

/* File: tb/fsc_irq_model.sv */
// model: interrupt controller raising an entry-able exception after a delay
`timescale 1ns/10ps
module fsc_irq_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench request
    input wire logic req_i,
    input wire logic [7:0] dly_i,
    // towards the controller
    output logic entry_able_o
);
    logic [7:0] cnt_q;
    // the exception stays pending until the bench withdraws it, as a real one would
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i) begin
            cnt_q <= 8'h00;
            entry_able_o <= 1'b0;
        end else if (cnt_q == dly_i) begin
            entry_able_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : fsc_irq_model

/* File: tb/fsc_top_chk.sv */
// checker: port-level properties of the fault and sleep controller
`timescale 1ns/10ps
module fsc_top_chk
    import fsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic vector_read_error_flag_err_i,
    input wire logic [FSC_USE_N-1:0] use_err_i,
    input wire logic nmi_active_i,
    input wire logic hard_active_i,
    input wire logic nmi_i,
    input wire logic debug_halt_i,
    input wire logic wait_interrupt_instr_i,
    input wire logic entry_able_i,
    input wire logic fault_take_o,
    input wire fsc_class_t fault_class_o,
    input wire logic lockup_o,
    input wire logic issue_stop_o,
    input wire logic cpu_clk_gate_o,
    input wire logic sys_clk_stop_o,
    input wire logic pll_off_o,
    input wire logic flash_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic nmi_lock_q;
    // frozen at lockup entry: was the nmi handler running then
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_lock_q <= 1'b0;
        end else if (!lockup_o) begin
            nmi_lock_q <= nmi_active_i;
        end
    end
    vector_read_error_flag_hard_a: assert property (
        vector_read_error_flag_err_i |=> fault_take_o && fault_class_o == FSC_CLS_HARD) else $error("vector error");
    nest_esc_a: assert property (
        (|use_err_i) && (nmi_active_i || hard_active_i) |=> fault_class_o == FSC_CLS_HARD)
        else $error("nested fault not escalated");
    lock_entry_a: assert property (
        vector_read_error_flag_err_i && hard_active_i && !nmi_i && !debug_halt_i |=> lockup_o) else $error("no lockup");
    lock_hold_a: assert property (
        lockup_o && !nmi_i && !debug_halt_i |=> lockup_o) else $error("lockup left");
    lock_quiet_a: assert property (
        lockup_o |-> issue_stop_o) else $error("lockup issuing");
    nmi_ignored_a: assert property (
        lockup_o && nmi_lock_q && !debug_halt_i |=> lockup_o) else $error("nmi freed lockup");
    nmi_exit_a: assert property (
        lockup_o && nmi_i && !nmi_lock_q && !vector_read_error_flag_err_i |=> !lockup_o) else $error("nmi ignored");
    wfi_sleep_a: assert property (
        wait_interrupt_instr_i && !entry_able_i && !issue_stop_o |=> issue_stop_o)
        else $error("no sleep");
    wake_int_a: assert property (
        issue_stop_o && !lockup_o && entry_able_i && !vector_read_error_flag_err_i |=> !issue_stop_o)
        else $error("no wake");
    gate_rise_a: assert property (
        $rose(issue_stop_o) && !lockup_o |=> cpu_clk_gate_o) else $error("clock not gated");
    deep_set_a: assert property (
        sys_clk_stop_o |-> cpu_clk_gate_o && pll_off_o && flash_off_o) else $error("deep split");
    cover property (lockup_o && nmi_i);
    cover property (sys_clk_stop_o);
    cover property ($fell(issue_stop_o));
endmodule : fsc_top_chk

/* File: tb/fsc_top_tb.sv */
// testbench: fault classes, escalation, lockup and sleep against a bench model
`timescale 1ns/10ps
module fsc_top_tb
    import fsc_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vector_read_error_flag_err_i, no_execute_fetch_i;
    logic [7:0] wb_adr_i, irq_dly;
    logic [3:0] wb_sel_i, prot_err_i, exec_prio_i;
    logic [31:0] wb_dat_i, wb_dat_o, prot_addr_i, bus_addr_i, q;
    logic [4:0] bus_err_i;
    logic [5:0] use_err_i;
    logic bus_entry_push_i, nmi_active_i, hard_active_i, nmi_i, debug_halt_i, irq_req;
    logic wait_interrupt_instr_i, wait_event_instr_i, send_event_instr_i, exit_to_thread_i;
    logic entry_able_i, new_pending_i, interrupt_mask_bit_i, fault_mask_bit_i, fault_take_o;
    logic lockup_o, issue_stop_o, defer_handler_o, cpu_clk_gate_o, sys_clk_stop_o, pll_off_o;
    logic flash_off_o;
    fsc_class_t fault_class_o;
    logic [31:0] seed = 32'h22CFE33D;
    int n_mismatch, n_tests;
    int ex[10];
    fsc_top u_fsc_top (.*);
    fsc_irq_model u_fsc_irq_model (.clk_i, .rst_i, .req_i(irq_req), .dly_i(irq_dly),
        .entry_able_o(entry_able_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        chk(i < 20, 1'b1, "bus answer");
        if (i == 20) stop_test();
    endtask : wb
    task automatic rc(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
        chk(q, ex[a >> 2], "register read");
    endtask : rc
    // status registers clear on one, control registers keep only their fields
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        ex[a >> 2] = (a < 8'h10) ? ex[a >> 2] & ~d : d & ((a == 8'h1C) ? 32'h1FF : 32'h7);
    endtask : wr
    task automatic flt(input int c, input int b, input fsc_class_t ecl);
        logic [31:0] a;
        seed = lfsr(seed);
        a = seed;
        @(posedge clk_i);
        {prot_addr_i, bus_addr_i} <= {a, a};
        case (c)
            0: vector_read_error_flag_err_i <= 1'b1;
            1: prot_err_i <= 4'(1 << b);
            2: bus_err_i <= 5'(1 << b);
            3: use_err_i <= 6'(1 << b);
            default: no_execute_fetch_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {vector_read_error_flag_err_i, prot_err_i, bus_err_i, use_err_i, no_execute_fetch_i} <= '0;
        #1;
        chk(fault_take_o, 1'b1, "fault taken");
        chk(fault_class_o, ecl, "fault class");
        case (c)
            0: ex[0] |= 1;
            2: ex[2] |= 1 << b;
            3: ex[3] |= 1 << b;
            default: ex[1] |= 1 << b;
        endcase
        if (c == 1 || c == 4) ex[4] = a;
        if (c == 2 && b < 4) ex[5] = a;
        if (c != 0 && ecl == FSC_CLS_HARD) ex[0] |= 2;
    endtask : flt
    task automatic pl(input int k);
        @(posedge clk_i);
        case (k)
            0: wait_interrupt_instr_i <= 1'b1;
            1: wait_event_instr_i <= 1'b1;
            2: send_event_instr_i <= 1'b1;
            3: exit_to_thread_i <= 1'b1;
            4: nmi_i <= 1'b1;
            5: debug_halt_i <= 1'b1;
            default: new_pending_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {wait_interrupt_instr_i, wait_event_instr_i, send_event_instr_i, exit_to_thread_i} <= '0;
        {nmi_i, debug_halt_i, new_pending_i} <= '0;
        #1;
    endtask : pl
    task automatic wk(input logic dfr);
        int i;
        seed = lfsr(seed);
        @(posedge clk_i);
        {irq_req, irq_dly} <= {1'b1, 4'h0, seed[3:0]};
        for (i = 0; i < 40 && issue_stop_o !== 1'b0; i++) @(posedge clk_i);
        #1;
        chk(issue_stop_o, 1'b0, "woken");
        chk(defer_handler_o, dfr, "handler deferral");
        if (issue_stop_o !== 1'b0) stop_test();
        @(posedge clk_i) irq_req <= 1'b0;
        ex[9] = 0;
    endtask : wk
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, vector_read_error_flag_err_i, prot_err_i} = '0;
        {no_execute_fetch_i, prot_addr_i, bus_addr_i, bus_err_i, use_err_i, irq_req} = '0;
        {bus_entry_push_i, nmi_active_i, hard_active_i, nmi_i, debug_halt_i, irq_dly} = '0;
        {wait_interrupt_instr_i, wait_event_instr_i, send_event_instr_i, exit_to_thread_i} = '0;
        {new_pending_i, interrupt_mask_bit_i, fault_mask_bit_i} = '0;
        {rst_i, wb_sel_i, exec_prio_i} = {1'b1, 4'hF, FSC_THREAD_PRIO};
        ex = '{default: 0};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 10; k++) rc(8'(k * 4));
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0, "unmapped read");
        flt(3, 5, FSC_CLS_HARD);
        wr(8'h20, 32'h7);
        for (int c = 1; c < 4; c++) begin
            for (int b = 0; b < 3 + c; b++) begin
                flt(c, b, fsc_class_t'(c));
                rc(8'(c * 4));
            end
        end
        for (int k = 0; k < 6; k++) rc(8'(k * 4));
        wr(8'h00, 32'h0);
        rc(8'h00);
        for (int k = 0; k < 4; k++) wr(8'(k * 4), 32'hFFFFFFFF);
        flt(4, 0, FSC_CLS_PROT);
        rc(8'h04);
        wr(8'h1C, 32'h0C0);
        @(posedge clk_i) exec_prio_i <= 4'h3;
        flt(3, 1, FSC_CLS_HARD);
        @(posedge clk_i) exec_prio_i <= 4'h4;
        flt(3, 1, FSC_CLS_USE);
        @(posedge clk_i) exec_prio_i <= 4'h0;
        flt(2, 0, FSC_CLS_HARD);
        @(posedge clk_i) bus_entry_push_i <= 1'b1;
        flt(2, 0, FSC_CLS_BUS);
        @(posedge clk_i) {bus_entry_push_i, exec_prio_i, hard_active_i} <= 6'h31;
        flt(0, 0, FSC_CLS_HARD);
        for (int k = 0; k < 4; k++) rc(8'(k * 4));
        chk({lockup_o, issue_stop_o}, 2'b11, "lockup");
        pl(4);
        chk(lockup_o, 1'b0, "nmi release");
        @(posedge clk_i) {hard_active_i, nmi_active_i} <= 2'b01;
        flt(3, 0, FSC_CLS_HARD);
        pl(4);
        chk(lockup_o, 1'b1, "nmi inside nmi lockup");
        pl(5);
        chk(lockup_o, 1'b0, "debug release");
        @(posedge clk_i) {nmi_active_i, interrupt_mask_bit_i} <= 2'b01;
        wr(8'h18, 32'h1);
        pl(0);
        chk(issue_stop_o, 1'b1, "sleep on wait");
        @(posedge clk_i) #1;
        chk({cpu_clk_gate_o, sys_clk_stop_o, flash_off_o}, 3'h7, "deep sleep");
        ex[9] = 2;
        rc(8'h24);
        wk(1'b1);
        @(posedge clk_i) interrupt_mask_bit_i <= 1'b0;
        wr(8'h18, 32'h2);
        pl(3);
        @(posedge clk_i) #1;
        chk({issue_stop_o, cpu_clk_gate_o, sys_clk_stop_o}, 3'h6, "light sleep");
        wk(1'b0);
        @(posedge clk_i) {irq_req, irq_dly} <= 9'h100;
        repeat (3) @(posedge clk_i);
        pl(0);
        chk(issue_stop_o, 1'b0, "wake condition already true");
        @(posedge clk_i) irq_req <= 1'b0;
        wr(8'h18, 32'h4);
        pl(2);
        pl(1);
        chk(issue_stop_o, 1'b0, "event pending");
        pl(1);
        chk(issue_stop_o, 1'b1, "event sleep");
        pl(6);
        chk(issue_stop_o, 1'b0, "new pending wake");
        pl(1);
        chk(issue_stop_o, 1'b0, "pending set event");
        pl(1);
        wk(1'b0);
        stop_test();
    end
endmodule : fsc_top_tb
bind fsc_top fsc_top_chk u_fsc_top_chk (.*);
